/* File: idsp_top.sv */
/*
  instruction/data split memory unit with ahb-lite register slave.
  assumes segment translation is done upstream and an access request
  arrives as a logical address plus physical translation each cycle.
*/
// Register access over AHB-Lite is this design's own decision.
// How it works
// R1: split register bits 7:6 ignore writes and read zero.
// R2: bit 5 clear: inversions apply to fetches and data alike.
// R3: bit 5 set: inversions apply to data accesses only.
// R4: bit 4 set holds battery ram select active continuously.
// R5: bit 3 inverts a19 of data-segment accesses before bank select.
// R6: bit 2 inverts a16 of data-segment accesses.
// R7: bit 1 inverts a19 of root accesses before bank select.
// R8: bit 0 inverts a16 of root accesses.
// R9: split region is root plus data segment, lowest 52k.
// R10: reset bank-zero control blocks the boot write strobe.
// R11: after reset fetching starts at address zero of boot memory.
// R12: opcode 0xff restarts to 0x70 pushing pc; stack defaults to 0.
// R13: a16 inversion moves 64k, a19 inversion moves 512k.
// R14: inversion is xor after translation, before bank decode.
module idsp_top import idsp_pkg::*; #(
  parameter int PHYS_W = IDSP_PHYS_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // memory access request
  input wire logic acc_valid,
  input wire logic acc_fetch,
  input wire logic acc_write,
  input wire logic [15:0] acc_logical,
  input wire logic [PHYS_W-1:0] acc_phys,
  input wire logic acc_dseg,
  input wire logic [7:0] acc_opcode,
  // memory side
  output logic [PHYS_W-1:0] mem_addr_q,
  output logic mem_upper_bank_q,
  output logic boot_chip_select_n_q,
  output logic boot_output_enable_n_q,
  output logic boot_write_strobe_n_q,
  output logic battery_ram_select_n_q,
  // fetch control
  output logic [15:0] fetch_pc_q,
  output logic restart_q,
  output logic [15:0] stack_ptr_q
);

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [7:0] split_q;
  logic [7:0] bank0_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] rd_addr_q;
  logic addr_ok;

  assign addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      rd_pend_q <= addr_ok && !hwrite;
      if (addr_ok) begin
        wr_addr_q <= haddr[7:0];
        rd_addr_q <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      split_q <= IDSP_SPLIT_RST;
      bank0_q <= IDSP_BANK0_RST; // [R10]
    end else if (wr_pend_q) begin
      if (wr_addr_q == IDSP_SPLIT_OFS) begin
        split_q <= hwdata[7:0] & IDSP_SPLIT_WMASK; // [R1]
      end
      if (wr_addr_q == IDSP_BANK0_OFS) begin
        bank0_q <= hwdata[7:0];
      end
    end
  end

  // read data registered in the address phase; zero-wait answers
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        IDSP_SPLIT_OFS: begin
          hrdata <= {24'h00_0000, split_q & IDSP_SPLIT_WMASK}; // [R1]
        end
        IDSP_BANK0_OFS: hrdata <= {24'h00_0000, bank0_q};
        IDSP_STAT_OFS: hrdata <= {15'h0000, restart_q, fetch_pc_q};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // address modification
  // ------------------------------------------------------------
  logic in_split;
  logic in_root;
  logic [PHYS_W-1:0] mod_addr;

  // root and data segment together cover logical 0000..cfff
  assign in_split = acc_logical < IDSP_SPLIT_TOP; // [R9]
  assign in_root = in_split && !acc_dseg;

  idsp_xlate u_xlate (
    .phys_in(acc_phys),
    .in_root(in_root),
    .in_dseg(in_split && acc_dseg),
    .is_fetch(acc_fetch),
    .split_ctl(split_q),
    .phys_out(mod_addr)
  );

  // ------------------------------------------------------------
  // memory strobes
  // ------------------------------------------------------------
  logic upper;
  assign upper = mod_addr[IDSP_A19]; // bank choice after inversion [R14]

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_addr_q <= '0;
      mem_upper_bank_q <= 1'b0;
      boot_chip_select_n_q <= 1'b1;
      boot_output_enable_n_q <= 1'b1;
      boot_write_strobe_n_q <= 1'b1;
    end else begin
      mem_addr_q <= mod_addr;
      mem_upper_bank_q <= upper;
      boot_chip_select_n_q <= !(acc_valid && !upper); // [R11]
      boot_output_enable_n_q <= !(acc_valid && !upper && !acc_write);
      // writes to boot memory blocked while inhibit bit is set
      boot_write_strobe_n_q <= !(acc_valid && !upper && acc_write
        && !bank0_q[IDSP_BANK0_WINH_BIT]); // [R10]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      battery_ram_select_n_q <= 1'b1;
    end else begin
      // forcing saves decode delay on slow battery-backed ram
      battery_ram_select_n_q <= !(split_q[IDSP_FORCE_CS1_BIT]
        || (acc_valid && upper)); // [R4]
    end
  end

  // ------------------------------------------------------------
  // fetch sequencing
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_pc_q <= IDSP_RESET_PC; // [R11]
      restart_q <= 1'b0;
      stack_ptr_q <= IDSP_STACK_RST; // [R12]
    end else begin
      restart_q <= 1'b0;
      if (acc_valid && acc_fetch) begin
        if (acc_opcode == IDSP_RESTART_OP) begin
          // push of the return pc wraps the stack downward
          fetch_pc_q <= IDSP_RESTART_VEC; // [R12]
          stack_ptr_q <= stack_ptr_q - 16'h0002;
          restart_q <= 1'b1;
        end else begin
          fetch_pc_q <= fetch_pc_q + 16'h0001;
        end
      end
    end
  end

endmodule : idsp_top

/* File: idsp_pkg.sv */
/*
  package for the instruction/data split memory unit: register offsets,
  field positions, reset values and fetch/restart constants.
  assumes a 32-bit ahb-lite register bus with word-aligned registers.
*/
package idsp_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] IDSP_SPLIT_OFS = 8'h10;
  localparam logic [7:0] IDSP_BANK0_OFS = 8'h14;
  localparam logic [7:0] IDSP_STAT_OFS = 8'h18;

  // ------------------------------------------------------------
  // split control fields
  // ------------------------------------------------------------
  localparam int IDSP_ROOT_A16_BIT = 0;
  localparam int IDSP_ROOT_A19_BIT = 1;
  localparam int IDSP_DSEG_A16_BIT = 2;
  localparam int IDSP_DSEG_A19_BIT = 3;
  localparam int IDSP_FORCE_CS1_BIT = 4;
  localparam int IDSP_DATA_ONLY_BIT = 5;
  localparam logic [7:0] IDSP_SPLIT_WMASK = 8'h3f;
  localparam logic [7:0] IDSP_SPLIT_RST = 8'h00;

  // ------------------------------------------------------------
  // bank-zero control: bit 3 set inhibits the boot write strobe
  // ------------------------------------------------------------
  localparam int IDSP_BANK0_WINH_BIT = 3;
  localparam logic [7:0] IDSP_BANK0_RST = 8'h08;

  // ------------------------------------------------------------
  // address space and fetch constants
  // ------------------------------------------------------------
  localparam int IDSP_PHYS_W = 20;
  localparam int IDSP_A16 = 16;
  localparam int IDSP_A19 = 19;
  localparam logic [15:0] IDSP_SPLIT_TOP = 16'hd000;
  localparam logic [15:0] IDSP_RESET_PC = 16'h0000;
  localparam logic [7:0] IDSP_RESTART_OP = 8'hff;
  localparam logic [15:0] IDSP_RESTART_VEC = 16'h0070;
  localparam logic [15:0] IDSP_STACK_RST = 16'h0000;

endpackage : idsp_pkg

/* File: idsp_xlate.sv */
/*
  combinational address modifier: applies a16/a19 inversions to a
  translated physical address before bank selection.
  assumes the caller supplies segment decode and access kind.
*/
module idsp_xlate import idsp_pkg::*; (
  // access
  input wire logic [IDSP_PHYS_W-1:0] phys_in,
  input wire logic in_root,
  input wire logic in_dseg,
  input wire logic is_fetch,
  // control
  input wire logic [7:0] split_ctl,
  // result
  output logic [IDSP_PHYS_W-1:0] phys_out
);

  logic apply;
  logic inv16;
  logic inv19;

  always_comb begin
    // data-only mode leaves instruction fetches untouched
    apply = !(split_ctl[IDSP_DATA_ONLY_BIT] && is_fetch); // [R2] [R3]
    inv16 = apply && ((in_root && split_ctl[IDSP_ROOT_A16_BIT]) // [R8]
      || (in_dseg && split_ctl[IDSP_DSEG_A16_BIT])); // [R6]
    inv19 = apply && ((in_root && split_ctl[IDSP_ROOT_A19_BIT]) // [R7]
      || (in_dseg && split_ctl[IDSP_DSEG_A19_BIT])); // [R5]
    phys_out = phys_in;
    // xor moves the access by 64k or 512k [R13] [R14]
    phys_out[IDSP_A16] = phys_in[IDSP_A16] ^ inv16;
    phys_out[IDSP_A19] = phys_in[IDSP_A19] ^ inv19;
  end

endmodule : idsp_xlate

/* File: idsp_top_asserts.sv */
/* checker on the ports of idsp_top.
   assumes it is bound to every idsp_top instance. */
module idsp_top_asserts import idsp_pkg::*; #(
  parameter int PHYS_W = IDSP_PHYS_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // access
  input wire logic acc_valid,
  input wire logic acc_fetch,
  input wire logic [15:0] acc_logical,
  input wire logic [PHYS_W-1:0] acc_phys,
  input wire logic [7:0] acc_opcode,
  // memory and fetch
  input wire logic [PHYS_W-1:0] mem_addr_q,
  input wire logic mem_upper_bank_q,
  input wire logic boot_chip_select_n_q,
  input wire logic boot_write_strobe_n_q,
  input wire logic battery_ram_select_n_q,
  input wire logic [15:0] fetch_pc_q,
  input wire logic restart_q,
  input wire logic [15:0] stack_ptr_q
);
  default clocking @(posedge clk); endclocking
  a_bank_is_a19: assert property (
    disable iff (rst) mem_upper_bank_q == mem_addr_q[19])
    else $error("bank select differs from a19");
  a_only_a16_a19: assert property (
    disable iff (rst) acc_valid |=>
    ((mem_addr_q ^ $past(acc_phys)) & 20'h6_ffff) == '0)
    else $error("bits other than a16 a19 changed");
  a_outside_kept: assert property (
    disable iff (rst) acc_valid && acc_logical >= IDSP_SPLIT_TOP
    |=> mem_addr_q == $past(acc_phys))
    else $error("address above split region modified");
  a_boot_low_bank: assert property (
    disable iff (rst) !boot_chip_select_n_q |-> !mem_upper_bank_q)
    else $error("boot select on upper bank");
  a_boot_sel_valid: assert property (
    disable iff (rst) !boot_chip_select_n_q |-> $past(acc_valid))
    else $error("boot select without access");
  a_cs1_upper: assert property (
    disable iff (rst) $past(acc_valid) && mem_upper_bank_q
    |-> !battery_ram_select_n_q)
    else $error("battery ram not selected on upper bank");
  a_restart_vec: assert property (
    disable iff (rst) acc_valid && acc_fetch && acc_opcode == 8'hff
    |=> restart_q && fetch_pc_q == 16'h0070
    && stack_ptr_q == $past(stack_ptr_q) - 16'h0002)
    else $error("restart did not vector");
  a_reset_state: assert property (
    rst |=> fetch_pc_q == 16'h0000 && stack_ptr_q == 16'h0000
    && boot_write_strobe_n_q)
    else $error("reset state wrong");
  c_restart: cover property (restart_q);
  c_upper: cover property (mem_upper_bank_q);
  c_boot: cover property (!boot_chip_select_n_q);
endmodule : idsp_top_asserts

bind idsp_top idsp_top_asserts #(.PHYS_W(PHYS_W)) u_idsp_top_asserts (.*);

/* File: idsp_mem_model.sv */
/* boot flash model: erased, every fetched byte reads ff.
   assumes the opcode is taken in the cycle the fetch request stands. */
module idsp_mem_model (
  // access request
  input wire logic acc_valid,
  input wire logic acc_fetch,
  // read data
  output logic [7:0] acc_opcode
);
  timeunit 1ns;
  timeprecision 1ns;
  // the core samples the byte with the request, so the flash answers
  // while the fetch stands; an idle bus shows the inverse of ff
  assign acc_opcode = (acc_valid && acc_fetch) ? 8'hff : 8'h00;
endmodule : idsp_mem_model

/* File: test_ifetch_data_address_split.sv */
/* self-checking bench for idsp_top.
   assumes idsp_mem_model feeds the fetched opcode. */
module test_ifetch_data_address_split import idsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, acc_valid = 0;
  logic acc_fetch = 0, acc_write = 0, acc_dseg = 0, hresp, restart_q;
  logic hreadyout, mem_upper_bank_q, boot_chip_select_n_q;
  logic boot_output_enable_n_q, boot_write_strobe_n_q;
  logic battery_ram_select_n_q;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] acc_logical = 0, fetch_pc_q, stack_ptr_q;
  logic [19:0] acc_phys = 0, mem_addr_q;
  logic [7:0] acc_opcode;
  wire logic hready;
  int errors = 0, n_checks = 0;
  // split, fetch, dseg, logical, phys, expected address
  logic [65:0] rows [11] = '{
    {8'h00, 2'h0, 16'h1000, 20'h0_1234, 20'h0_1234},
    {8'h01, 2'h0, 16'h1000, 20'h0_1234, 20'h1_1234},
    {8'h02, 2'h0, 16'h1000, 20'h0_1234, 20'h8_1234},
    {8'h02, 2'h0, 16'h1000, 20'h8_1234, 20'h0_1234},
    {8'h04, 2'h1, 16'h8000, 20'h0_1234, 20'h1_1234},
    {8'h08, 2'h1, 16'h8000, 20'h0_1234, 20'h8_1234},
    {8'h03, 2'h2, 16'h1000, 20'h0_1234, 20'h9_1234},
    {8'h23, 2'h2, 16'h1000, 20'h0_1234, 20'h0_1234},
    {8'h2c, 2'h1, 16'h8000, 20'h0_1234, 20'h9_1234},
    {8'h0f, 2'h1, 16'hd000, 20'h0_1234, 20'h0_1234},
    {8'h01, 2'h1, 16'h8000, 20'h0_1234, 20'h0_1234}};
  assign hready = hreadyout;
  idsp_top u_idsp_top (.*);
  idsp_mem_model u_idsp_mem_model (.*);
  initial forever #25 clk = ~clk;
  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task chk(input string n, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task hwait;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 16);
    if (hreadyout !== 1'b1) begin
      errors++;
      tally_and_finish;
    end
  endtask : hwait
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    hwrite <= w;
    haddr <= 32'(a);
    htrans <= 2'h2;
    hwait;
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    hwait;
    rd = hrdata;
  endtask : bus
  task acc(input logic f, w, g, input logic [15:0] l, logic [19:0] p);
    acc_valid <= 1;
    acc_fetch <= f;
    acc_write <= w;
    acc_dseg <= g;
    acc_logical <= l;
    acc_phys <= p;
    @(posedge clk);
    acc_valid <= 0;
    #1;
  endtask : acc
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    foreach (rows[k]) begin
      bus(1, IDSP_SPLIT_OFS, 32'(rows[k][65:58]));
      acc(rows[k][57], 0, rows[k][56], rows[k][55:40], rows[k][39:20]);
      chk("addr", 32'(mem_addr_q), 32'(rows[k][19:0]));
      chk("bank", 32'(mem_upper_bank_q), 32'(rows[k][19]));
    end
    $display("table done");
    bus(1, IDSP_SPLIT_OFS, 32'hffff_ffff);
    bus(0, IDSP_SPLIT_OFS, 0);
    chk("split", rd, 32'h0000_003f);
    @(posedge clk);
    chk("cs1", 32'(battery_ram_select_n_q), 0);
    bus(1, IDSP_SPLIT_OFS, 0);
    repeat (2) @(posedge clk);
    chk("cs1", 32'(battery_ram_select_n_q), 1);
    bus(0, 8'h1c, 32'h0000_0000);
    chk("unmapped", rd, 0);
    $display("register test done");
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    chk("pc", 32'(fetch_pc_q), 0);
    bus(0, IDSP_BANK0_OFS, 0);
    chk("bank0", rd, 32'h0000_0008);
    acc(0, 1, 0, 16'h0000, 20'h0_0000);
    chk("we", 32'(boot_write_strobe_n_q), 1);
    chk("cs0", 32'(boot_chip_select_n_q), 0);
    chk("oe", 32'(boot_output_enable_n_q), 1);
    acc(1, 0, 0, 16'h0000, 20'h0_0000);
    chk("oe", 32'(boot_output_enable_n_q), 0);
    chk("hresp", 32'(hresp), 0);
    chk("restart", 32'(restart_q), 1);
    chk("pc", 32'(fetch_pc_q), 32'h0000_0070);
    chk("sp", 32'(stack_ptr_q), 32'h0000_fffe);
    bus(1, IDSP_BANK0_OFS, 0);
    acc(0, 1, 0, 16'h0000, 20'h0_0000);
    chk("we", 32'(boot_write_strobe_n_q), 0);
    $display("reset test done");
    tally_and_finish;
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    tally_and_finish;
  end
endmodule : test_ifetch_data_address_split
